/* File: verilog/rswc_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

module rswc_ctrl #(
    parameter int POR_CYC = rswc_pkg::POR_MIN_CYC
) (
    input wire logic clk_in, // Crystal-derived clock, 100 MHz.
    input wire logic rst_in, // Power-on reset, async, high.
    input wire rswc_pkg::rswc_pins_t pins_in, // Asynchronous pins.
    input wire rswc_pkg::rswc_core_req_t core_req_in, // Core requests.
    input wire logic [7:0] recov_ctl_in, // Deep sleep recovery control.
    input wire logic reg_wr_in, // Register write strobe.
    input wire logic reg_rd_in, // Register read strobe.
    input wire logic [3:0] reg_bank_in, // Expanded register bank.
    input wire logic [3:0] reg_addr_in, // Location within bank.
    input wire logic [7:0] reg_wdata_in, // Write data.
    output logic [7:0] reg_rdata_out, // Read data.
    output logic core_reset_out, // Holds the core in reset.
    output logic cpu_clk_en_out, // Core clock gate enable.
    output logic crystal_osc_en_out, // Crystal oscillator enable.
    output logic timers_run_out, // Counter/timers enable.
    output logic [5:0] irq_en_out, // External interrupt inputs live.
    output logic [15:0] start_addr_out, // Restart address.
    output logic flags_we_out, // Pulse: core updates Z, S, V.
    output logic guard_armed_out, // Guard countdown is armed.
    output logic cfg_open_out // Config write window open.
);

    localparam int PW = $clog2(POR_CYC + 1);
    localparam int WW = $clog2(rswc_pkg::WIN_CYC + 1);
    localparam logic [PW-1:0] POR_LAST = PW'(POR_CYC);
    localparam logic [WW-1:0] WIN_LAST = WW'(rswc_pkg::WIN_CYC);

    rswc_pkg::rswc_pins_t pins_s;
    rswc_pkg::rswc_pins_t pins_d_r;
    rswc_pkg::rswc_state_t state_r, state_nxt;
    logic [PW-1:0] por_cnt_r, por_cnt_nxt;
    logic por_need_r, por_need_nxt;
    logic rearm_r, rearm_nxt;
    logic [WW-1:0] win_cnt_r, win_cnt_nxt;
    logic win_arm_r, win_arm_nxt;
    logic guard_arm_r, guard_arm_nxt;
    logic [rswc_pkg::GUARD_DIV_W-1:0] div_r, div_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic flags_r, flags_nxt;
    logic rc_tick, rec_rise, quiet, guard_run, timeout, cfg_hit;
    logic [3:0] tap;

    rswc_sync #(
        .W(4)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(pins_in),
        .q_out(pins_s)
    );

    // Edges are taken from the filtered levels, never from a raw stage.
    assign rc_tick = pins_s.rc_osc & ~pins_d_r.rc_osc;
    assign rec_rise = pins_s.recovery & ~pins_d_r.recovery;
    assign quiet = pins_s.supply_ok & ~pins_s.ext_reset;

    // The select bits choose which divider stage ends the count.
    always_comb begin
        case (cfg_r[rswc_pkg::CFG_TAP_LSB +: 2])
            2'h0: tap = rswc_pkg::GUARD_TAP0;
            2'h1: tap = rswc_pkg::GUARD_TAP1;
            2'h2: tap = rswc_pkg::GUARD_TAP2;
            default: tap = rswc_pkg::GUARD_TAP3;
        endcase
    end

    // The guard keeps counting in a sleep state only when told to.
    always_comb begin
        guard_run = guard_arm_r && (state_r == rswc_pkg::ST_RUN
            || (state_r == rswc_pkg::ST_PAUSE
                && cfg_r[rswc_pkg::CFG_PAUSE_RUN_BIT])
            || (state_r == rswc_pkg::ST_DEEP
                && cfg_r[rswc_pkg::CFG_DEEP_RUN_BIT]));
        timeout = guard_arm_r && div_r[tap];
    end

    assign cfg_hit = reg_bank_in == rswc_pkg::CFG_BANK
        && reg_addr_in == rswc_pkg::CFG_ADDR;

    // Sequencer: reset causes first, then the state's own exits.
    always_comb begin
        state_nxt = state_r;
        por_cnt_nxt = por_cnt_r;
        por_need_nxt = por_need_r;
        rearm_nxt = rearm_r;
        win_cnt_nxt = win_cnt_r;
        win_arm_nxt = win_arm_r;
        guard_arm_nxt = guard_arm_r;
        div_nxt = div_r;
        flags_nxt = 1'b0;
        if (guard_run && rc_tick) begin
            div_nxt = div_r + 1'b1;
        end
        if (!pins_s.supply_ok) begin
            state_nxt = rswc_pkg::ST_OFF;
            guard_arm_nxt = 1'b0;
        end else if (pins_s.ext_reset) begin
            // External reset holds the core; no delay is asked for.
            state_nxt = rswc_pkg::ST_HOLD;
            por_need_nxt = 1'b0;
            rearm_nxt = 1'b0;
            guard_arm_nxt = 1'b0;
        end else begin
            case (state_r)
                rswc_pkg::ST_OFF: begin
                    state_nxt = rswc_pkg::ST_HOLD;
                    por_cnt_nxt = '0;
                    por_need_nxt = 1'b1;
                    rearm_nxt = 1'b1;
                end
                rswc_pkg::ST_HOLD: begin
                    // The minimum elapses on the clock, the end on an RC tick.
                    if (!por_need_r || (por_cnt_r == POR_LAST
                        && rc_tick)) begin
                        state_nxt = rswc_pkg::ST_RUN;
                        win_cnt_nxt = '0;
                        win_arm_nxt = rearm_r;
                    end else if (por_cnt_r != POR_LAST) begin
                        por_cnt_nxt = por_cnt_r + 1'b1;
                    end
                end
                rswc_pkg::ST_RUN: begin
                    if (win_cnt_r != WIN_LAST) begin
                        win_cnt_nxt = win_cnt_r + 1'b1;
                    end
                    if (timeout) begin
                        state_nxt = rswc_pkg::ST_HOLD;
                    end else if (core_req_in.refresh) begin
                        guard_arm_nxt = 1'b1;
                        div_nxt = '0;
                        flags_nxt = 1'b1;
                    end else if (core_req_in.pause) begin
                        state_nxt = rswc_pkg::ST_PAUSE;
                    end else if (core_req_in.deep) begin
                        state_nxt = rswc_pkg::ST_DEEP;
                    end
                end
                rswc_pkg::ST_PAUSE: begin
                    if (timeout) begin
                        state_nxt = rswc_pkg::ST_HOLD;
                    end else if (core_req_in.irq_taken) begin
                        state_nxt = rswc_pkg::ST_RUN;
                    end
                end
                rswc_pkg::ST_DEEP: begin
                    // Only reset causes leave deep sleep.
                    if (timeout) begin
                        state_nxt = rswc_pkg::ST_HOLD;
                    end else if (rec_rise) begin
                        state_nxt = rswc_pkg::ST_HOLD;
                        por_cnt_nxt = '0;
                        por_need_nxt =
                            recov_ctl_in[rswc_pkg::RECOV_DELAY_BIT];
                        rearm_nxt = 1'b1;
                    end
                end
                default: state_nxt = rswc_pkg::ST_OFF;
            endcase
            // A guard bite restarts the delay and rearms the window.
            if (timeout && state_r != rswc_pkg::ST_HOLD
                && state_r != rswc_pkg::ST_OFF) begin
                por_cnt_nxt = '0;
                por_need_nxt = 1'b1;
                rearm_nxt = 1'b1;
                guard_arm_nxt = 1'b0;
            end
        end
        if (!guard_arm_nxt) begin
            div_nxt = '0;
        end
    end

    // Writes land only in the open window; reads never show the value.
    always_comb begin
        cfg_nxt = cfg_r;
        if (reg_wr_in && cfg_hit && cfg_open_out) begin
            cfg_nxt = reg_wdata_in & rswc_pkg::CFG_USED_MASK;
        end
    end

    // All state registers of the sequencer.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= rswc_pkg::ST_OFF;
            pins_d_r <= '0;
            por_cnt_r <= '0;
            por_need_r <= 1'b1;
            rearm_r <= 1'b1;
            win_cnt_r <= '0;
            win_arm_r <= 1'b0;
            guard_arm_r <= 1'b0;
            div_r <= '0;
            cfg_r <= rswc_pkg::CFG_RESET;
            flags_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pins_d_r <= pins_s;
            por_cnt_r <= por_cnt_nxt;
            por_need_r <= por_need_nxt;
            rearm_r <= rearm_nxt;
            win_cnt_r <= win_cnt_nxt;
            win_arm_r <= win_arm_nxt;
            guard_arm_r <= guard_arm_nxt;
            div_r <= div_nxt;
            cfg_r <= cfg_nxt;
            flags_r <= flags_nxt;
        end
    end

    // Outputs decode the registered state only.
    assign core_reset_out = state_r == rswc_pkg::ST_OFF
        || state_r == rswc_pkg::ST_HOLD;
    assign cpu_clk_en_out = state_r == rswc_pkg::ST_RUN
        || state_r == rswc_pkg::ST_HOLD;
    assign crystal_osc_en_out = state_r != rswc_pkg::ST_DEEP;
    assign timers_run_out = state_r == rswc_pkg::ST_RUN
        || state_r == rswc_pkg::ST_PAUSE;
    assign irq_en_out = timers_run_out ? rswc_pkg::IRQ_ALL : 6'h00;
    assign start_addr_out = rswc_pkg::RESTART_ADDR;
    assign flags_we_out = flags_r;
    assign guard_armed_out = guard_arm_r;
    assign cfg_open_out = win_arm_r && state_r == rswc_pkg::ST_RUN
        && win_cnt_r != WIN_LAST;
    assign reg_rdata_out = 8'h00;

    // Helper: cycles spent in the hold state, saturating at the minimum.
    logic [PW-1:0] hold_age_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_age_r <= '0;
        end else if (state_r != rswc_pkg::ST_HOLD) begin
            hold_age_r <= '0;
        end else if (hold_age_r != POR_LAST) begin
            hold_age_r <= hold_age_r + 1'b1;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_bypass_exit;
        state_r == rswc_pkg::ST_HOLD ##1 state_r == rswc_pkg::ST_RUN;
    endsequence

    chk_delay_min: assert property (
        (state_r == rswc_pkg::ST_HOLD && por_need_r && quiet
            && state_nxt == rswc_pkg::ST_RUN) |-> hold_age_r == POR_LAST)
        else $error("core released before delay minimum");

    chk_deep_bypass: assert property (
        (state_r == rswc_pkg::ST_DEEP && rec_rise && !timeout && quiet
            && !recov_ctl_in[rswc_pkg::RECOV_DELAY_BIT])
        |=> s_bypass_exit)
        else $error("deep sleep bypass did not restart at once");

    chk_pause_gate: assert property (
        state_r == rswc_pkg::ST_PAUSE |-> !cpu_clk_en_out
            && crystal_osc_en_out
            && timers_run_out && irq_en_out == 6'h3F)
        else $error("pause mode clocks wrong");

    chk_pause_hold: assert property (
        (state_r == rswc_pkg::ST_PAUSE && !core_req_in.irq_taken
            && !timeout && quiet) |=> state_r == rswc_pkg::ST_PAUSE)
        else $error("pause left without an interrupt");

    chk_deep_stop: assert property (
        (state_r == rswc_pkg::ST_DEEP && quiet && !timeout && !rec_rise)
        |=> !crystal_osc_en_out && !cpu_clk_en_out && !core_reset_out)
        else $error("deep sleep left without a reset cause");

    chk_guard_bite: assert property (
        (timeout && state_r == rswc_pkg::ST_RUN && quiet)
        |=> core_reset_out && !guard_armed_out ##1 core_reset_out)
        else $error("guard timeout did not reset the core");

    chk_guard_refresh: assert property (
        (state_r == rswc_pkg::ST_RUN && core_req_in.refresh && !timeout
            && quiet) |=> guard_armed_out && div_r == '0 && flags_we_out)
        else $error("refresh did not arm and restart the guard");

    chk_cfg_lock: assert property (
        !cfg_open_out |=> $stable(cfg_r))
        else $error("config changed outside the window");

    chk_rearm_bite: assert property (
        (timeout && state_r == rswc_pkg::ST_PAUSE && quiet)
        |=> por_need_r && rearm_r && state_r == rswc_pkg::ST_HOLD)
        else $error("guard reset did not rearm delay and window");

endmodule

`default_nettype wire

/* File: common/rswc_pkg.sv */
package rswc_pkg;

    // Clock and timing figures, each time in its own unit.
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_MIN_NS = 2500000;
    localparam int POR_MIN_CYC = (POR_MIN_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int WIN_PROC_CYC = 60;
    localparam int CRYSTAL_PER_PROC = 2;
    localparam int WIN_CYC = WIN_PROC_CYC * CRYSTAL_PER_PROC;

    // Guard countdown configuration register location and layout.
    localparam logic [3:0] CFG_BANK = 4'hF;
    localparam logic [3:0] CFG_ADDR = 4'hF;
    localparam logic [7:0] CFG_RESET = 8'h0C;
    localparam int CFG_TAP_LSB = 0;
    localparam int CFG_PAUSE_RUN_BIT = 2;
    localparam int CFG_DEEP_RUN_BIT = 3;
    localparam logic [7:0] CFG_USED_MASK = 8'h0F;

    // Divider taps picked by the two select bits.
    localparam int GUARD_DIV_W = 16;
    localparam logic [3:0] GUARD_TAP0 = 4'hA;
    localparam logic [3:0] GUARD_TAP1 = 4'hB;
    localparam logic [3:0] GUARD_TAP2 = 4'hC;
    localparam logic [3:0] GUARD_TAP3 = 4'hE;

    // Deep sleep recovery control: bit that asks for the power-on delay.
    localparam int RECOV_DELAY_BIT = 5;

    // Fixed restart address after deep sleep.
    localparam logic [15:0] RESTART_ADDR = 16'h000C;
    localparam logic [5:0] IRQ_ALL = 6'h3F;

    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_HOLD = 3'h1,
        ST_RUN = 3'h2,
        ST_PAUSE = 3'h3,
        ST_DEEP = 3'h4
    } rswc_state_t;

    // Pins from outside the clock domain.
    typedef struct packed {
        logic supply_ok;
        logic ext_reset;
        logic recovery;
        logic rc_osc;
    } rswc_pins_t;

    // One-cycle requests from the core, same clock.
    typedef struct packed {
        logic pause;
        logic deep;
        logic refresh;
        logic irq_taken;
    } rswc_core_req_t;

endpackage

/* File: verilog/rswc_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module rswc_sync #(
    parameter int W = 4
) (
    input wire logic clk_in, // System clock.
    input wire logic rst_in, // Asynchronous reset, high.
    input wire logic [W-1:0] d_in, // Asynchronous inputs.
    output logic [W-1:0] q_out // Filtered synchronous levels.
);

    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // A bit changes only once the second and third stage agree.
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always_comb begin
                q_nxt[i] = (ff2_r[i] == ff3_r[i]) ? ff3_r[i] : q_r[i];
            end
        end
    endgenerate

    // The first stage feeds only the second to keep metastability contained.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ff1_r <= '0;
            ff2_r <= '0;
            ff3_r <= '0;
            q_r <= '0;
        end else begin
            ff1_r <= d_in;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
            q_r <= q_nxt;
        end
    end

    assign q_out = q_r;

endmodule

`default_nettype wire

/* File: testbench/rswc_core_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Core stand-in: issues one-cycle requests and notes what it sees.
module rswc_core_model (
    input wire logic clk_in, // System clock.
    input wire logic core_reset_in, // Core held in reset.
    input wire logic flags_we_in, // Flag update pulse.
    input wire logic [15:0] start_addr_in, // Restart address.
    output rswc_pkg::rswc_core_req_t req_out, // Requests.
    output logic [15:0] fetch_pc_out, // First fetch address.
    output logic [7:0] flag_cnt_out // Flag updates seen.
);
    // Quiet until asked.
    initial begin
        req_out = '0;
        fetch_pc_out = 16'hFFFF;
        flag_cnt_out = 8'h00;
    end

    // Forget the last fetch while held, so a stale address cannot pass.
    always @(posedge core_reset_in) begin
        fetch_pc_out <= 16'hFFFF;
    end

    // The first fetch after a reset comes from the restart address.
    always @(negedge core_reset_in) begin
        fetch_pc_out <= start_addr_in;
    end

    // Each pulse stands for one update of zero, sign and overflow.
    always @(posedge clk_in) begin
        if (flags_we_in === 1'b1) begin
            flag_cnt_out <= flag_cnt_out + 8'h01;
        end
    end

    // Op 0 pause, 1 deep sleep, 2 refresh, 3 interrupt taken.
    task automatic issue(input logic [1:0] op);
        rswc_pkg::rswc_core_req_t r;
        r = '0;
        r.pause = (op == 2'h0);
        r.deep = (op == 2'h1);
        r.refresh = (op == 2'h2);
        r.irq_taken = (op == 2'h3);
        @(posedge clk_in);
        // A core held in reset executes nothing.
        while (core_reset_in === 1'b1) begin
            @(posedge clk_in);
        end
        // A no-op slot drains the pipeline before either sleep.
        if (op < 2'h2) begin
            @(posedge clk_in);
        end
        req_out <= r;
        @(posedge clk_in);
        req_out <= '0;
    endtask
endmodule

`default_nettype wire

/* File: testbench/reset_sleep_watchdog_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none

// Bench for the reset, sleep and guard countdown controller.
module reset_sleep_watchdog_ctrl_tb;
    // A short delay keeps the run brief; expectations scale with it.
    localparam int POR = 20;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    rswc_pkg::rswc_pins_t pins;
    rswc_pkg::rswc_core_req_t req;
    logic [7:0] recov, wdata, rdata, flag_cnt;
    logic wr, rd, core_rst, clk_en, osc_en, tmr, fl_we, armed, cfg_open;
    logic [3:0] bank, addr, rb, ra;
    logic [5:0] irq;
    logic [15:0] saddr, fetch_pc;
    logic [1:0] rc_div;
    int miscompares, cmp_count, cycles, rc_ticks, n, m, t, sel;

    rswc_ctrl #(.POR_CYC(POR)) DUT (.clk_in(clk_in), .rst_in(rst_in),
        .pins_in(pins), .core_req_in(req), .recov_ctl_in(recov),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_bank_in(bank),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .core_reset_out(core_rst), .cpu_clk_en_out(clk_en),
        .crystal_osc_en_out(osc_en), .timers_run_out(tmr), .irq_en_out(irq),
        .start_addr_out(saddr), .flags_we_out(fl_we),
        .guard_armed_out(armed), .cfg_open_out(cfg_open));

    rswc_core_model core (.clk_in(clk_in), .core_reset_in(core_rst),
        .flags_we_in(fl_we), .start_addr_in(saddr), .req_out(req),
        .fetch_pc_out(fetch_pc), .flag_cnt_out(flag_cnt));

    // Clock at 100 MHz.
    always #5 clk_in = ~clk_in;

    // RC oscillator at a quarter of the clock rate, and the hang limit.
    always @(posedge clk_in) begin
        rc_div <= rc_div + 2'h1;
        pins.rc_osc <= rc_div[1];
        if (rc_div == 2'h2) begin
            rc_ticks <= rc_ticks + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end

    // Compare one value and count the outcome.
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // One register access; the request stands across the edge that takes
    // it and drops on that same edge; every access checks that read data stays zero.
    task automatic bus(input logic w, input logic [3:0] b, a,
        input logic [7:0] d);
        @(posedge clk_in);
        wr <= w;
        rd <= ~w;
        bank <= b;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        check("rdata", rdata, 8'h00);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // Bounded wait for the core reset to reach a level.
    task automatic wait_rst(input logic lvl, output int c);
        c = 0;
        while (core_rst !== lvl && c < 50000) begin
            @(posedge clk_in);
            #1;
            c = c + 1;
        end
    endtask

    // Let a number of RC ticks pass.
    task automatic wait_ticks(input int k);
        int s;
        s = rc_ticks;
        while (rc_ticks - s < k) begin
            @(posedge clk_in);
        end
        #1;
    endtask

    // Ticks to timeout for a tap select, from the divider taps.
    function automatic int exp_ticks(input int s);
        case (s)
            0: return 1 << rswc_pkg::GUARD_TAP0;
            1: return 1 << rswc_pkg::GUARD_TAP1;
            2: return 1 << rswc_pkg::GUARD_TAP2;
            default: return 1 << rswc_pkg::GUARD_TAP3;
        endcase
    endfunction

    // Pin synchronisers blur a tick count by a few ticks either way.
    function automatic logic in_win(input int v, e);
        return v >= e - 3 && v <= e + 3;
    endfunction

    // Verdict and end of run.
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        pins = '0;
        recov = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        bank = 4'h0;
        addr = 4'h0;
        rc_div = 2'h0;
        rc_ticks = 0;
        cycles = 0;
        miscompares = 0;
        cmp_count = 0;
        sel = $urandom(51);
        repeat (20) @(posedge clk_in);
        #1;
        check("rst_core", core_rst, 1);
        check("rst_armed", armed, 0);
        check("rst_addr", saddr, 16'h000C);
        @(posedge clk_in);
        rst_in <= 1'b0;
        pins.supply_ok <= 1'b1;
        wait_rst(1'b0, n);
        check("por_len", n >= POR && n <= POR + 20, 1);
        check("cfg_open", cfg_open, 1);
        $display("test power_on done");

        // Random tap; stray writes to neighbouring places must not land.
        sel = $urandom % 2;
        rb = 4'($urandom % 15);
        ra = 4'($urandom % 15);
        bus(1'b1, 4'hF, 4'hF, {4'($urandom), 4'(sel)});
        bus(1'b1, rb, 4'hF, 8'h01 ^ sel[7:0]);
        bus(1'b1, 4'hF, ra, 8'h01 ^ sel[7:0]);
        bus(1'b0, 4'hF, 4'hF, 8'h00);
        wait_ticks(100);
        check("idle_guard", armed, 0);
        core.issue(2'h2);
        #1;
        check("flags_we", fl_we, 1);
        check("armed", armed, 1);
        wait_ticks(500);
        core.issue(2'h2);
        m = rc_ticks;
        wait_rst(1'b1, n);
        t = rc_ticks - m;
        check("g_ticks", in_win(t, exp_ticks(sel)), 1);
        check("disarmed", armed, 0);
        wait_rst(1'b0, n);
        check("g_hold", n >= POR, 1);
        check("reopen", cfg_open, 1);
        check("flag_cnt", flag_cnt, 8'h02);
        $display("test guard done");

        // Pause with the guard frozen: only run time may count.
        bus(1'b1, 4'hF, 4'hF, 8'h00);
        core.issue(2'h2);
        m = rc_ticks;
        core.issue(2'h0);
        t = rc_ticks - m;
        #1;
        check("p_clk", clk_en, 0);
        check("p_osc", osc_en, 1);
        check("p_tmr", tmr, 1);
        check("p_irq", irq, rswc_pkg::IRQ_ALL);
        core.issue(2'h2);
        wait_ticks(1500);
        check("p_stay", clk_en, 0);
        check("p_frozen", core_rst, 0);
        check("p_flags", flag_cnt, 8'h03);
        core.issue(2'h3);
        m = rc_ticks;
        #1;
        check("p_wake", clk_en, 1);
        wait_rst(1'b1, n);
        t = t + rc_ticks - m;
        check("p_ticks", in_win(t, exp_ticks(0)), 1);
        wait_rst(1'b0, n);
        repeat (125) @(posedge clk_in);
        #1;
        check("closed", cfg_open, 0);
        $display("test pause done");

        // Deep sleep left by recovery, without and with the delay.
        for (int b = 0; b < 2; b++) begin
            @(posedge clk_in);
            // Bit 5 alone decides; the other bits are noise.
            recov <= (b == 1) ? (8'h20 | 8'($urandom))
                : (8'hDF & 8'($urandom));
            core.issue(2'h1);
            #1;
            check("d_osc", osc_en, 0);
            check("d_clk", clk_en, 0);
            core.issue(2'h3);
            #1;
            check("d_stay", osc_en, 0);
            @(posedge clk_in);
            pins.recovery <= 1'b1;
            wait_rst(1'b1, n);
            wait_rst(1'b0, n);
            check("d_hold", (b == 1) ? n >= POR : n <= 3, 1);
            check("d_pc", fetch_pc, 16'h000C);
            check("d_open", cfg_open, 1);
            @(posedge clk_in);
            pins.recovery <= 1'b0;
        end

        // Guard bite while paused, with counting in pause turned on.
        bus(1'b1, 4'hF, 4'hF, 8'h04);
        core.issue(2'h2);
        m = rc_ticks;
        core.issue(2'h0);
        wait_rst(1'b1, n);
        t = rc_ticks - m;
        check("pb_ticks", in_win(t, exp_ticks(0)), 1);
        wait_rst(1'b0, n);
        check("pb_hold", n >= POR, 1);
        check("pb_open", cfg_open, 1);
        $display("test pause_bite done");

        // External reset out of deep sleep leaves the window shut.
        repeat (125) @(posedge clk_in);
        core.issue(2'h1);
        @(posedge clk_in);
        pins.ext_reset <= 1'b1;
        wait_rst(1'b1, n);
        @(posedge clk_in);
        pins.ext_reset <= 1'b0;
        wait_rst(1'b0, n);
        check("x_osc", osc_en, 1);
        check("x_shut", cfg_open, 0);

        // Supply loss and return runs the full delay again.
        @(posedge clk_in);
        pins.supply_ok <= 1'b0;
        wait_rst(1'b1, n);
        @(posedge clk_in);
        pins.supply_ok <= 1'b1;
        wait_rst(1'b0, n);
        check("sup_len", n >= POR, 1);
        $display("test resets done");
        print_verdict();
    end
endmodule

`default_nettype wire
